// file: rtl/oms_defines.svh
// Constants for the oscillator mode select block
`ifndef OMS_DEFINES_SVH
`define OMS_DEFINES_SVH
`define OMS_SEL_W          3
`define OMS_SEL_LP         3'h0
`define OMS_SEL_XT         3'h1
`define OMS_SEL_HS         3'h2
`define OMS_SEL_EXTERNAL_CLOCK_PIN_FREE_MODE       3'h3
`define OMS_SEL_INTERNAL_OSC_BOTH_PINS_MODE     3'h4
`define OMS_SEL_INTERNAL_OSC_CLKOUT_MODE     3'h5
`define OMS_SEL_RESISTOR_CAPACITOR_PIN_FREE_MODE       3'h6
`define OMS_SEL_RC         3'h7
`define OMS_CLKOUT_DIV     4
`define OMS_START_WAIT_DEF 1024
`endif

// file: rtl/oms_pkg.sv
// Types for the oscillator mode select block
package oms_pkg;
    typedef enum logic [7:0] {
        low_power_crystal_mode          = 8'h01,
        crystal_resonator_mode          = 8'h02,
        high_speed_crystal_mode         = 8'h04,
        resistor_capacitor_clkout_mode  = 8'h08,
        resistor_capacitor_pin_free_mode = 8'h10,
        internal_osc_clkout_mode        = 8'h20,
        internal_osc_both_pins_mode     = 8'h40,
        external_clock_pin_free_mode    = 8'h80
    } oms_mode_type;
    typedef enum logic [1:0] {
        oms_src_crystal  = 2'h0,
        oms_src_rc       = 2'h1,
        oms_src_internal = 2'h2,
        oms_src_external = 2'h3
    } oms_src_type;
endpackage

// file: rtl/oms_if.sv
// Decoded pin roles carried from the decoder to the top
`timescale 1ns/1ps
`default_nettype none
interface oms_if;
    import oms_pkg::*;
    oms_mode_type mode;          // One-hot decoded mode
    oms_src_type  src;           // Clock source class
    logic         out_clkdiv;    // Clock-out pin drives Fosc/4
    logic         out_gpio;      // Clock-out pin is port A bit 6
    logic         in_gpio;       // Clock-in pin is port A bit 7
    logic         needs_start;   // Start-up wait required
    modport dec (output mode, output src, output out_clkdiv, output out_gpio, output in_gpio, output needs_start);
    modport top (input mode, input src, input out_clkdiv, input out_gpio, input in_gpio, input needs_start);
endinterface
`default_nettype wire

// file: rtl/oms_decode.sv
// Combinational decoder from select field to mode and pin roles
`timescale 1ns/1ps
`default_nettype none
`include "oms_defines.svh"
module oms_decode
    import oms_pkg::*;
(
    input  wire logic [`OMS_SEL_W-1:0] sel,
    oms_if.dec                         roles
);
    // Every code maps to one mode, so no illegal value exists
    always_comb begin
        roles.out_clkdiv  = 1'b0;
        roles.out_gpio    = 1'b0;
        roles.in_gpio     = 1'b0;
        roles.needs_start = 1'b1;
        roles.src         = oms_src_crystal;
        roles.mode        = low_power_crystal_mode;
        unique case (sel)
            `OMS_SEL_LP:   roles.mode = low_power_crystal_mode;
            `OMS_SEL_XT:   roles.mode = crystal_resonator_mode;
            `OMS_SEL_HS:   roles.mode = high_speed_crystal_mode;
            `OMS_SEL_RC: begin
                roles.mode       = resistor_capacitor_clkout_mode;
                roles.src        = oms_src_rc;
                roles.out_clkdiv = 1'b1;
            end
            `OMS_SEL_RESISTOR_CAPACITOR_PIN_FREE_MODE: begin
                roles.mode     = resistor_capacitor_pin_free_mode;
                roles.src      = oms_src_rc;
                roles.out_gpio = 1'b1;
            end
            `OMS_SEL_INTERNAL_OSC_CLKOUT_MODE: begin
                roles.mode       = internal_osc_clkout_mode;
                roles.src        = oms_src_internal;
                roles.out_clkdiv = 1'b1;
                roles.in_gpio    = 1'b1;
            end
            `OMS_SEL_INTERNAL_OSC_BOTH_PINS_MODE: begin
                roles.mode     = internal_osc_both_pins_mode;
                roles.src      = oms_src_internal;
                roles.out_gpio = 1'b1;
                roles.in_gpio  = 1'b1;
            end
            `OMS_SEL_EXTERNAL_CLOCK_PIN_FREE_MODE: begin
                roles.mode        = external_clock_pin_free_mode;
                roles.src         = oms_src_external;
                roles.needs_start = 1'b0;
                roles.out_gpio    = 1'b1;
            end
        endcase
    end
endmodule // oms_decode
`default_nettype wire

// file: rtl/oms_top.sv
// Oscillator mode select: latches the mode at reset and routes the oscillator pins
`timescale 1ns/1ps
`default_nettype none
`include "oms_defines.svh"
module oms_top
    import oms_pkg::*;
#(
    parameter int START_WAIT = `OMS_START_WAIT_DEF  // Start-up wait in clocks
) (
    input  wire logic                  clk,
    input  wire logic                  rst,
    input  wire logic [`OMS_SEL_W-1:0] osc_mode_select,     // Configuration field
    input  wire logic                  wake,                // Pulse: exit from sleep
    input  wire logic                  port_a_bit6_out,     // Port data for bit 6
    input  wire logic                  port_a_bit6_oe,      // Port drive for bit 6
    input  wire logic                  port_a_bit7_out,     // Port data for bit 7
    input  wire logic                  port_a_bit7_oe,      // Port drive for bit 7
    input  wire logic                  clock_out_pin_in,    // Clock-out pad level
    input  wire logic                  clock_in_pin_in,     // Clock-in pad level
    output logic                       clock_out_pin_out,
    output logic                       clock_out_pin_oe,
    output logic                       clock_in_pin_out,
    output logic                       clock_in_pin_oe,
    output logic                       port_a_bit6_in,      // Synchronised pad read
    output logic                       port_a_bit7_in,
    output oms_mode_type               mode,                // Latched mode
    output oms_src_type                clock_source,
    output logic                       clock_ready          // Start-up wait over
);
    // How the block works
    //
    // The configuration field is a strap: it is copied into sel_q on the
    // first clock edge after reset is released and never looked at again
    // until the next reset. Everything else in the block follows from the
    // decoded mode of that copy, so a field that wanders at run time can
    // never move a pin role under the feet of the port logic.
    //
    // The decoder is purely combinational and hands its pin roles over in
    // an interface; this module only registers the pad drive, so every pad
    // output and pad enable comes straight from a flip-flop and cannot
    // glitch while the decode settles.
    //
    // The divided clock is modelled as a square wave at a quarter of clk,
    // taken from the top bit of a two-bit counter. It is good enough for
    // test and synchronisation use; it is not phase-aligned to anything.
    //
    // The start-up counter stands for the oscillator settling time. It is
    // restarted by reset and by every exit from sleep. The external-clock
    // mode skips it entirely, since the board already supplies a clean
    // clock there.
    //
    // Pad reads pass two flip-flops, because the pad level is not of this
    // clock's domain, and are forced low when the pin is not a port bit so
    // that oscillator activity never leaks into port reads.
    //
    // Limitation: a wake pulse in the external-clock mode still drops ready
    // for one cycle; the ready flag is a level, so a read in that cycle sees the gap.

    // Decoded roles shared with the decoder
    oms_if roles ();

    // Captured configuration
    logic [`OMS_SEL_W-1:0] sel_q;     // Field captured at reset release
    logic [`OMS_SEL_W-1:0] sel_d;     // Next value of the captured field
    logic                  loaded_q;  // Field has been captured
    logic                  loaded_d;  // Next value of the capture flag

    // Divided clock
    logic [1:0]            div_q;     // Fosc/4 divider
    logic [1:0]            div_d;     // Next divider count
    logic                  cko_q;     // Registered clock-out level
    logic                  cko_d;     // Next clock-out level

    // Start-up wait
    logic [31:0]           wait_q;    // Start-up counter
    logic [31:0]           wait_d;    // Next start-up count
    logic                  rdy_q;     // Start-up wait is over
    logic                  rdy_d;     // Next ready level

    // Pad read synchronisers
    logic [1:0]            s6_q;      // Clock-out pad synchroniser
    logic [1:0]            s6_d;      // Next clock-out pad stages
    logic [1:0]            s7_q;      // Clock-in pad synchroniser
    logic [1:0]            s7_d;      // Next clock-in pad stages

    // Pad drive registers
    logic                  d6_q;      // Clock-out pad data
    logic                  d6_d;      // Next clock-out pad data
    logic                  d7_q;      // Clock-in pad data
    logic                  d7_d;      // Next clock-in pad data
    logic                  e6_q;      // Clock-out pad enable
    logic                  e6_d;      // Next clock-out pad enable
    logic                  e7_q;      // Clock-in pad enable
    logic                  e7_d;      // Next clock-in pad enable

    // Mode decoder; its roles are stable once the field is captured
    oms_decode u_dec (
        .sel   (sel_q),
        .roles (roles)
    );

    // Capture once after reset; a strap must not pass through async reset
    always_comb begin
        sel_d    = sel_q;
        loaded_d = 1'b1;
        if (!loaded_q) begin
            sel_d = osc_mode_select;
        end
    end

    // Divider, start-up counter, pad logic
    always_comb begin
        div_d  = div_q + 2'h1;
        cko_d  = div_q[1];      // Half high, half low over four clocks
        wait_d = wait_q;
        rdy_d  = rdy_q;
        if (!loaded_q || wake) begin
            wait_d = 32'h0;
            rdy_d  = 1'b0;
        end else if (!rdy_q) begin
            // External clock skips the wait; crystal, RC and internal-oscillator modes count it out
            if (!roles.needs_start || wait_q >= 32'(START_WAIT - 1)) begin
                rdy_d = 1'b1;
            end else begin
                wait_d = wait_q + 32'h1;
            end
        end
        // Two stages per pad; only the second stage is ever read
        s6_d = {s6_q[0], clock_out_pin_in};
        s7_d = {s7_q[0], clock_in_pin_in};
        // Clock-out pad: divided clock, port bit 6, or oscillator use
        if (roles.out_clkdiv) begin
            d6_d = cko_q;
            e6_d = 1'b1;
        end else if (roles.out_gpio) begin
            d6_d = port_a_bit6_out;
            e6_d = port_a_bit6_oe;
        end else begin
            d6_d = 1'b0;
            e6_d = 1'b0;  // Crystal drive stays analog
        end
        // Clock-in pad: port bit 7 only in internal modes
        if (roles.in_gpio) begin
            d7_d = port_a_bit7_out;
            e7_d = port_a_bit7_oe;
        end else begin
            d7_d = 1'b0;
            e7_d = 1'b0;  // Clock or oscillator input
        end
    end

    // State registers; reset is synchronous, so the strap copy is taken
    // on a clean edge and never through an asynchronous path
    always_ff @(posedge clk) begin
        if (rst) begin
            sel_q    <= `OMS_SEL_LP;
            loaded_q <= 1'b0;
            div_q    <= 2'h0;
            cko_q    <= 1'b0;
            wait_q   <= 32'h0;
            rdy_q    <= 1'b0;
            s6_q     <= 2'h0;
            s7_q     <= 2'h0;
            d6_q     <= 1'b0;
            e6_q     <= 1'b0;
            d7_q     <= 1'b0;
            e7_q     <= 1'b0;
        end else begin
            sel_q    <= sel_d;
            loaded_q <= loaded_d;
            div_q    <= div_d;
            cko_q    <= cko_d;
            wait_q   <= wait_d;
            rdy_q    <= rdy_d;
            s6_q     <= s6_d;
            s7_q     <= s7_d;
            d6_q     <= d6_d;
            e6_q     <= e6_d;
            d7_q     <= d7_d;
            e7_q     <= e7_d;
        end
    end

    // Outputs; port reads are zero when the pin is not a port bit
    // Pad drive comes from flip-flops only, one cycle after the roles
    assign clock_out_pin_out = d6_q;
    assign clock_out_pin_oe  = e6_q;
    assign clock_in_pin_out  = d7_q;
    assign clock_in_pin_oe   = e7_q;
    assign port_a_bit6_in    = roles.out_gpio & s6_q[1];
    assign port_a_bit7_in    = roles.in_gpio & s7_q[1];
    assign mode              = roles.mode;
    assign clock_source      = roles.src;
    assign clock_ready       = rdy_q;
endmodule // oms_top
`default_nettype wire

// file: dv/oms_partner.sv
// Model of the crystal, RC network or clock source at the oscillator pins
`timescale 1ns/1ps
`default_nettype none
module oms_partner (
    input  wire logic       clk,
    input  wire logic [2:0] sel,   // Mode the board is built for
    input  wire logic       ext6,  // Board level on a released bit 6 pin
    input  wire logic       ext7,  // Board level on a released bit 7 pin
    input  wire logic       out6,
    input  wire logic       oe6,
    input  wire logic       out7,
    input  wire logic       oe7,
    output logic            pad6,
    output logic            pad7
);
    logic osc_q = 1'h0;  // Free-running oscillation of the outside part
    always @(posedge clk) osc_q <= ~osc_q;
    // Crystal sits across both pins, external clock feeds clock-in only
    always_comb begin
        pad7 = oe7 ? out7 : ((sel == 3'h4 || sel == 3'h5) ? ext7 : osc_q);
        pad6 = oe6 ? out6 : ((sel < 3'h3) ? ~osc_q : ext6);
    end
endmodule // oms_partner
`default_nettype wire

// file: dv/oms_monitor.sv
// Checker for the oscillator mode select top level
`timescale 1ns/1ps
`default_nettype none
module oms_monitor
    import oms_pkg::*;
#(
    parameter int START_WAIT = 8  // Start-up wait in clocks
) (
    input wire logic         clk,
    input wire logic         rst,
    input wire logic         port_a_bit6_oe,
    input wire logic         port_a_bit7_oe,
    input wire logic         clock_out_pin_out,
    input wire logic         clock_out_pin_oe,
    input wire logic         clock_in_pin_oe,
    input wire logic         port_a_bit6_in,
    input wire logic         port_a_bit7_in,
    input wire oms_mode_type mode,
    input wire logic         clock_ready
);
    logic [7:0] cnt_q;           // Cycles since reset release, saturating
    logic [7:0] cnt_d;
    logic       st, g6, g7, dv;  // Settled; pins free; divider mode
    // Pin roles read straight off the one-hot mode bits
    always_comb begin
        cnt_d = (cnt_q == 8'hFF) ? cnt_q : cnt_q + 8'h01;
        st = cnt_q > 8'h03;
        g6 = mode[7] | mode[6] | mode[4];
        g7 = mode[6] | mode[5];
        dv = mode[3] | mode[5];
    end
    always_ff @(posedge clk) cnt_q <= rst ? 8'h00 : cnt_d;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    mode_onehot_a: assert property ($onehot(mode)) else $error("mode not one-hot");
    mode_hold_a: assert property (st |-> $stable(mode)) else $error("mode moved");
    div_wave_a: assert property (dv && $rose(clock_out_pin_out) |=>
        clock_out_pin_out ##1 !clock_out_pin_out) else $error("bad divider wave");
    div_drive_a: assert property (st && dv |-> clock_out_pin_oe) else $error("divider undriven");
    pin6_free_a: assert property (st && g6 && $past(port_a_bit6_oe) && $past(port_a_bit6_oe, 2)
        |-> clock_out_pin_oe) else $error("bit 6 not driven");
    pin7_free_a: assert property (st && g7 && $past(port_a_bit7_oe) && $past(port_a_bit7_oe, 2)
        |-> clock_in_pin_oe) else $error("bit 7 not driven");
    read_gate_a: assert property (st |-> (g6 || !port_a_bit6_in) && (g7 || !port_a_bit7_in))
        else $error("read not gated");
    ext_ready_a: assert property (cnt_q == 8'h06 |-> clock_ready == mode[7]) else $error("ready");
    wait_done_a: assert property (int'(cnt_q) == START_WAIT + 2 |-> clock_ready) else $error("wait");
endmodule // oms_monitor
bind oms_top oms_monitor #(.START_WAIT(START_WAIT)) u_mon (.*);
`default_nettype wire

// file: dv/test_oscillator_mode_select.sv
// Self-checking bench for the oscillator mode select block
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin n_errors++; $display("[ERR] %s exp %0h got %0h", n, e, s); end end
module test_oscillator_mode_select;
    import oms_pkg::*;
    logic         clk = 1'h0, rst = 1'h1, wake = 1'h0, o6 = 1'h0, e6 = 1'h0, o7 = 1'h0, e7 = 1'h0, x6 = 1'h0, x7 = 1'h0;
    logic [2:0]   sel = 3'h0, m = 3'h0;  // Field at the pins; board build
    logic         p6, p7, co, coe, ci, cie, i6, i7, rdy;
    oms_mode_type mode;
    oms_src_type  src;
    int           n_errors = 0, cmp_count = 0;
    logic [31:0]  rs = 32'h9B4E55EB;     // Fixed seed keeps runs repeatable
    logic [7:0]   mt [8] = '{8'h01, 8'h02, 8'h04, 8'h80, 8'h40, 8'h20, 8'h10, 8'h08};
    logic [1:0]   ct [8] = '{2'h0, 2'h0, 2'h0, 2'h3, 2'h2, 2'h2, 2'h1, 2'h1};
    oms_top #(.START_WAIT(8)) dut (.clk(clk), .rst(rst), .osc_mode_select(sel), .wake(wake),
        .port_a_bit6_out(o6), .port_a_bit6_oe(e6), .port_a_bit7_out(o7), .port_a_bit7_oe(e7),
        .clock_out_pin_in(p6), .clock_in_pin_in(p7), .clock_out_pin_out(co), .clock_out_pin_oe(coe),
        .clock_in_pin_out(ci), .clock_in_pin_oe(cie), .port_a_bit6_in(i6), .port_a_bit7_in(i7),
        .mode(mode), .clock_source(src), .clock_ready(rdy));
    oms_partner far (.clk(clk), .sel(m), .ext6(x6), .ext7(x7), .out6(co), .oe6(coe), .out7(ci),
        .oe7(cie), .pad6(p6), .pad7(p7));
    function automatic logic [31:0] rnd();
        rs = rs ^ (rs << 13);
        rs = rs ^ (rs >> 17);
        rs = rs ^ (rs << 5);
        return rs;
    endfunction
    task automatic w(input int n);
        repeat (n) @(posedge clk);
    endtask
    task final_report();
        if (n_errors == 0 && cmp_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial forever #4 clk = ~clk;
    // Watchdog well past the expected run of about 656 cycles
    initial begin
        #20000;
        n_errors++;
        final_report();
    end
    // Every mode twice, each with a fresh reset and random pin traffic
    initial begin
        for (int k = 0; k < 16; k++) begin
            logic [31:0] r;
            logic [2:0]  s;
            logic        g6, g7;
            r = rnd();
            s = k[2:0];
            g6 = s inside {3'h3, 3'h4, 3'h6};
            g7 = s inside {3'h4, 3'h5};
            w(1);
            rst <= 1'h1;
            sel <= s;
            m <= s;
            w(12);
            rst <= 1'h0;
            w(1);
            sel <= r[2:0];
            w(5);
            #1;
            `CHK("mode", mt[s], mode)
            `CHK("source", ct[s], src)
            `CHK("ready", s == 3'h3, rdy)
            w(12);
            o6 <= r[3];
            e6 <= 1'h1;
            o7 <= r[4];
            e7 <= 1'h1;
            w(4);
            #1;
            `CHK("ready", 1'h1, rdy)
            `CHK("out6 oe", s > 3'h2, coe)
            `CHK("out7 oe", g7, cie)
            if (g6) `CHK("out6", r[3], co)
            if (g7) `CHK("out7", r[4], ci)
            w(1);
            e6 <= 1'h0;
            e7 <= 1'h0;
            x6 <= r[5];
            x7 <= r[6];
            wake <= 1'h1;
            w(1);
            wake <= 1'h0;
            w(4);
            #1;
            `CHK("in6", g6 & r[5], i6)
            `CHK("in7", g7 & r[6], i7)
            `CHK("ready", s == 3'h3, rdy)
        end
        final_report();
    end
endmodule // test_oscillator_mode_select
`default_nettype wire
